// >>> core/spc_ctl.sv
// spc_ctl: enable and direction control of the serial port, with
// avalon-mm register slave, sticky interrupt status and dma request gating
// assumes serial core flags are synchronous levels and errors one-cycle pulses
//
// Behaviour
// R1: with the data interrupt enable clear, tx-empty and rx-full raise no interrupt.
// R2: underrun, collision, abort and overrun always raise an interrupt; here they always set status, but irq needs the mask bit set.
// R3: with the data interrupt enable set, tx-empty and rx-full assertion raise an interrupt; here they set status, but irq needs the mask bit set.
// R4: software using dma or polling is expected to clear the data interrupt enable.
// R5: bits 6 and 0 form the mode field and 00 disables the serial port.
// R6: when disabled, the rate generator runs as a timer if its control bit is 1.
// R7: in receive-only mode tx-empty still shows but its interrupt and dma request are held off.
// R8: in receive-only mode as slave the serial data output sends all ones.
// R9: in receive-only mode as master software still writes transmit data to start a transfer.
// R10: in transmit-only mode rx-full still shows but its interrupt and dma request are held off.
// R11: in duplex mode both flags drive their interrupts and dma requests.
// R12: disabled with rate control 1 enables both the timer and its time-out interrupt; here the time-out sets status, but irq needs the mask bit set.
// R13: the control register reads back as written and a new mode acts from the next clock.
`timescale 1ns/1ns
module spc_ctl
  import spc_pkg::*;
(
  input wire logic clock, // system clock, 100 MHz
  input wire logic rst, // async reset, active high
  input wire logic [25:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [3:0] avs_byteenable, // byte lanes
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic tx_empty_flag, // transmit data register empty
  input wire logic rx_full_flag, // receive data register full
  input wire spc_err_t err_events, // error pulses
  input wire logic tx_shift_bit, // shifter output bit
  output logic serial_data_out, // bit toward the pad
  output logic port_enabled, // serial port active
  output spc_mode_t port_mode, // decoded direction mode
  output spc_cfg_t port_cfg, // phase, polarity, wire-or, master
  output spc_dma_t dma_req, // dma requests
  output logic timer_run, // rate generator timer running
  output logic irq // level interrupt
);
  // ---- mode decode used by several paths
  function automatic spc_mode_t decode_mode(input logic [7:0] ctl);
    logic [1:0] f;
    f = {ctl[`SPC_BIT_EN_HI], ctl[`SPC_BIT_EN_LO]};
    case (f)
      2'b00: decode_mode = SPC_OFF;
      2'b01: decode_mode = SPC_RX_ONLY;
      2'b10: decode_mode = SPC_TX_ONLY;
      default: decode_mode = SPC_DUPLEX;
    endcase
  endfunction

  function automatic logic tx_dir_on(input spc_mode_t m);
    tx_dir_on = (m == SPC_TX_ONLY) || (m == SPC_DUPLEX);
  endfunction

  function automatic logic rx_dir_on(input spc_mode_t m);
    rx_dir_on = (m == SPC_RX_ONLY) || (m == SPC_DUPLEX);
  endfunction

  // ---- state
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [`SPC_ST_WIDTH-1:0] stat_reg;
  logic [`SPC_ST_WIDTH-1:0] stat_next;
  logic [`SPC_ST_WIDTH-1:0] mask_reg;
  logic [`SPC_ST_WIDTH-1:0] mask_next;
  logic [15:0] reload_reg;
  logic [15:0] reload_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic tx_empty_prev_reg;
  logic rx_full_prev_reg;
  logic sdo_reg;
  logic sdo_next;

  logic [23:0] word_idx;
  logic wr_take;
  logic rd_start;
  logic [15:0] timer_count;
  logic timer_timeout;
  logic [`SPC_ST_WIDTH-1:0] set_vec;
  logic [`SPC_ST_WIDTH-1:0] clr_vec;
  logic [`SPC_ST_WIDTH-1:0] live_vec;
  spc_mode_t mode;
  logic data_irq_enable;
  logic tx_rise;
  logic rx_rise;

  assign word_idx = avs_address[25:2];
  assign mode = decode_mode(ctrl_reg);
  assign data_irq_enable = ctrl_reg[`SPC_BIT_DATA_IRQ_ENABLE];
  assign tx_rise = tx_empty_flag && !tx_empty_prev_reg;
  assign rx_rise = rx_full_flag && !rx_full_prev_reg;

  // ---- bus handshake: one wait cycle, then the answer
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wr_take = avs_write && ack_reg;
  assign rd_start = avs_read && !ack_reg;

  always_comb begin
    ack_next = (avs_read || avs_write) && !ack_reg;
    rdata_next = rdata_reg;
    if (rd_start) begin
      case (word_idx)
        `SPC_CTRL_IDX: rdata_next = {24'h000000, ctrl_reg};
        `SPC_STAT_IDX: rdata_next = {25'h0000000, stat_reg};
        `SPC_MASK_IDX: rdata_next = {25'h0000000, mask_reg};
        `SPC_RELOAD_IDX: rdata_next = {16'h0000, reload_reg};
        `SPC_COUNT_IDX: rdata_next = {16'h0000, timer_count};
        `SPC_FLAGS_IDX: rdata_next = {28'h0000000, 2'b00, rx_full_flag, tx_empty_flag};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // ---- control, mask and reload writes
  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    reload_next = reload_reg;
    if (wr_take) begin
      case (word_idx)
        // R13 stored as written
        `SPC_CTRL_IDX: begin
          if (avs_byteenable[0]) begin
            ctrl_next = avs_writedata[7:0];
          end
        end
        `SPC_MASK_IDX: begin
          if (avs_byteenable[0]) begin
            mask_next = avs_writedata[`SPC_ST_WIDTH-1:0];
          end
        end
        `SPC_RELOAD_IDX: begin
          if (avs_byteenable[0]) begin
            reload_next[7:0] = avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            reload_next[15:8] = avs_writedata[15:8];
          end
        end
        default: begin
          ctrl_next = ctrl_reg;
        end
      endcase
    end
  end

  // ---- interrupt event sources
  always_comb begin
    set_vec = '0;
    // R1 R3 R7 data events gated
    set_vec[`SPC_ST_TX_EMPTY] = tx_rise && data_irq_enable && tx_dir_on(mode);
    // R10 R11 rx event gated
    set_vec[`SPC_ST_RX_FULL] = rx_rise && data_irq_enable && rx_dir_on(mode);
    // R2 errors always enabled
    set_vec[`SPC_ST_UNDERRUN] = err_events.tx_underrun_flag;
    set_vec[`SPC_ST_COLLISION] = err_events.collision;
    set_vec[`SPC_ST_ABORT] = err_events.abort_flag;
    set_vec[`SPC_ST_OVERRUN] = err_events.rx_overrun_flag;
    // R12 timer time-out
    set_vec[`SPC_ST_TIMEOUT] = timer_timeout;
  end

  always_comb begin
    clr_vec = '0;
    if (wr_take && (word_idx == `SPC_STAT_IDX) && avs_byteenable[0]) begin
      clr_vec = avs_writedata[`SPC_ST_WIDTH-1:0];
    end
    // set wins over a clear in the same cycle
    stat_next = (stat_reg & ~clr_vec) | set_vec;
  end

  // ---- data bits only reach the line while enabled
  always_comb begin
    live_vec = stat_reg & mask_reg;
    // R1 data interrupts off
    if (!data_irq_enable) begin
      live_vec[`SPC_ST_TX_EMPTY] = 1'b0;
      live_vec[`SPC_ST_RX_FULL] = 1'b0;
    end
  end

  // ---- serial data output
  always_comb begin
    sdo_next = tx_shift_bit;
    // R8 slave receive-only sends ones
    if ((mode == SPC_RX_ONLY) && !ctrl_reg[`SPC_BIT_MMEN]) begin
      sdo_next = 1'b1;
    end
    // R5 disabled port idles high
    if (mode == SPC_OFF) begin
      sdo_next = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `SPC_CTRL_RST;
      stat_reg <= `SPC_STAT_RST;
      mask_reg <= `SPC_MASK_RST;
      reload_reg <= `SPC_RELOAD_RST;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      tx_empty_prev_reg <= 1'b0;
      rx_full_prev_reg <= 1'b0;
      sdo_reg <= 1'b1;
    end else begin
      ctrl_reg <= ctrl_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      reload_reg <= reload_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      tx_empty_prev_reg <= tx_empty_flag;
      rx_full_prev_reg <= rx_full_flag;
      sdo_reg <= sdo_next;
    end
  end

  // R6 timer only while disabled
  assign timer_run = (mode == SPC_OFF) && ctrl_reg[`SPC_BIT_RGCTL];

  spc_rate_timer u_timer (
    .clock(clock),
    .rst(rst),
    .run(timer_run),
    .reload(reload_reg),
    .count(timer_count),
    .timeout(timer_timeout)
  );

  // R9 master receive-only still needs software writes; shifter start is external
  // R5 mode field decode
  assign port_enabled = (mode != SPC_OFF);
  assign port_mode = mode;
  assign port_cfg.phase = ctrl_reg[`SPC_BIT_PHASE];
  assign port_cfg.clk_pol = ctrl_reg[`SPC_BIT_CLKPOL];
  assign port_cfg.wire_or = ctrl_reg[`SPC_BIT_WOR];
  assign port_cfg.master_en = ctrl_reg[`SPC_BIT_MMEN];
  // R7 R10 R11 dma direction gating
  assign dma_req.tx_dma_req = tx_empty_flag && tx_dir_on(mode);
  assign dma_req.rx_dma_req = rx_full_flag && rx_dir_on(mode);
  assign serial_data_out = sdo_reg;
  assign avs_readdata = rdata_reg;
  assign irq = |live_vec;
endmodule // spc_ctl

// >>> core/spc_cfg.svh
// spc_cfg.svh: offsets, field positions, reset values and counts of the port control
// assumes inclusion by bare name from the package and the bench
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// word indices; byte address is four times the index
`define SPC_CTRL_IDX 24'hFFE262
`define SPC_STAT_IDX 24'hFFE263
`define SPC_MASK_IDX 24'hFFE264
`define SPC_RELOAD_IDX 24'hFFE265
`define SPC_COUNT_IDX 24'hFFE266
`define SPC_FLAGS_IDX 24'hFFE267

// control register field positions
`define SPC_BIT_DATA_IRQ_ENABLE 7
`define SPC_BIT_EN_HI 6
`define SPC_BIT_RGCTL 5
`define SPC_BIT_PHASE 4
`define SPC_BIT_CLKPOL 3
`define SPC_BIT_WOR 2
`define SPC_BIT_MMEN 1
`define SPC_BIT_EN_LO 0

// status and mask field positions
`define SPC_ST_TX_EMPTY 0
`define SPC_ST_RX_FULL 1
`define SPC_ST_UNDERRUN 2
`define SPC_ST_COLLISION 3
`define SPC_ST_ABORT 4
`define SPC_ST_OVERRUN 5
`define SPC_ST_TIMEOUT 6
`define SPC_ST_WIDTH 7

// reset values
`define SPC_CTRL_RST 8'h00
`define SPC_STAT_RST 7'h00
`define SPC_MASK_RST 7'h00
`define SPC_RELOAD_RST 16'hFFFF
`define SPC_COUNT_RST 16'hFFFF

`endif

// >>> core/spc_pkg.sv
// spc_pkg: types shared by the port control and its rate timer
// assumes spc_cfg.svh on the include path
package spc_pkg;
  `include "spc_cfg.svh"

  typedef enum logic [1:0] {
    SPC_OFF,
    SPC_RX_ONLY,
    SPC_TX_ONLY,
    SPC_DUPLEX
  } spc_mode_t;

  // error events from the serial core, one-cycle pulses
  typedef struct packed {
    logic tx_underrun_flag;
    logic collision;
    logic abort_flag;
    logic rx_overrun_flag;
  } spc_err_t;

  // configuration bits handed to the shifter and pad logic
  typedef struct packed {
    logic phase;
    logic clk_pol;
    logic wire_or;
    logic master_en;
  } spc_cfg_t;

  // data path requests toward the dma logic
  typedef struct packed {
    logic tx_dma_req;
    logic rx_dma_req;
  } spc_dma_t;
endpackage

// >>> core/spc_rate_timer.sv
// spc_rate_timer: 16-bit reload down counter used as a general timer
// assumes run is a level from the control logic on the same clock
`timescale 1ns/1ns
module spc_rate_timer
  import spc_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rst, // async reset, active high
  input wire logic run, // timer function enabled
  input wire logic [15:0] reload, // reload value
  output logic [15:0] count, // current count
  output logic timeout // one-cycle pulse at wrap
);
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic timeout_reg;
  logic timeout_next;

  always_comb begin
    count_next = reload;
    timeout_next = 1'b0;
    if (run) begin
      if (count_reg == 16'h0000) begin
        count_next = reload;
        timeout_next = 1'b1;
      end else begin
        count_next = count_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg <= `SPC_COUNT_RST;
      timeout_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      timeout_reg <= timeout_next;
    end
  end

  assign count = count_reg;
  assign timeout = timeout_reg;
endmodule // spc_rate_timer

// >>> bench/spc_ctl_asserts.sv
// spc_ctl_asserts: port-level checks of the serial port control
// assumes binding to spc_ctl, one clock domain
`timescale 1ns/1ns
module spc_ctl_asserts
  import spc_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rst, // async reset
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic avs_waitrequest, // stall
  input wire logic tx_empty_flag, // tx level
  input wire logic rx_full_flag, // rx level
  input wire spc_err_t err_events, // error pulses
  input wire logic tx_shift_bit, // shifter bit
  input wire logic serial_data_out, // pad bit
  input wire logic port_enabled, // port active
  input wire spc_mode_t port_mode, // mode
  input wire spc_cfg_t port_cfg, // config bits
  input wire spc_dma_t dma_req, // dma requests
  input wire logic timer_run, // timer running
  input wire logic irq // interrupt
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_tx_dma_gate: assert property (dma_req.tx_dma_req == (tx_empty_flag && port_mode[1]))
    else $error("tx dma request gating wrong");
  a_rx_dma_gate: assert property (dma_req.rx_dma_req == (rx_full_flag && port_mode[0]))
    else $error("rx dma request gating wrong");
  a_timer_when_off: assert property (timer_run |-> port_mode == SPC_OFF)
    else $error("timer runs while port enabled");
  a_slave_rx_ones: assert property ((port_mode == SPC_RX_ONLY && !port_cfg.master_en) |=> serial_data_out)
    else $error("slave receive-only output not one");
  a_duplex_data_out: assert property (port_mode == SPC_DUPLEX |=> serial_data_out == $past(tx_shift_bit))
    else $error("duplex output not shifter bit");
  a_port_enable_off: assert property (port_enabled == (port_mode != SPC_OFF))
    else $error("enable does not follow mode");
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("register access not answered in one cycle");
  a_irq_has_cause: assert property ($rose(irq) |-> $past(|err_events || tx_empty_flag || rx_full_flag || avs_write || timer_run))
    else $error("interrupt rose without cause");
endmodule // spc_ctl_asserts

// >>> bench/spc_peer.sv
// spc_peer: serial peer and core flags seen by the control block
// assumes commands from the bench on the rising clock edge
`timescale 1ns/1ns
module spc_peer
  import spc_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rst, // async reset
  input wire logic tx_cmd, // tx register empty wanted
  input wire logic rx_cmd, // rx register full wanted
  input wire spc_err_t err_cmd, // error to report
  output logic tx_empty_flag, // tx level
  output logic rx_full_flag, // rx level
  output spc_err_t err_events, // error pulses
  output logic tx_shift_bit // changes every cycle
);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_empty_flag <= 1'b0;
      rx_full_flag <= 1'b0;
      err_events <= '0;
      tx_shift_bit <= 1'b0;
    end else begin
      tx_empty_flag <= tx_cmd;
      rx_full_flag <= rx_cmd;
      err_events <= err_cmd;
      tx_shift_bit <= ~tx_shift_bit;
    end
  end
endmodule // spc_peer

// >>> bench/spc_ctl_bench.sv
// spc_ctl_bench: self-checking bench of the serial port control
// assumes spc_pkg compiled first and spc_cfg.svh on the include path
`timescale 1ns/1ns
`include "spc_cfg.svh"
module spc_ctl_bench
  import spc_pkg::*;
;
  typedef struct {logic [7:0] ctl; spc_mode_t m; logic tr; logic [1:0] dma;} spc_row_t;
  logic clock, rst, avs_read, avs_write, avs_waitrequest, tx_cmd, rx_cmd;
  logic tx_empty_flag, rx_full_flag, tx_shift_bit, serial_data_out, port_enabled, timer_run, irq;
  logic [25:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  spc_err_t err_cmd, err_events;
  spc_mode_t port_mode;
  spc_cfg_t port_cfg;
  spc_dma_t dma_req;
  int mismatches, comparisons;
  spc_row_t rows [6] = '{'{8'h00, SPC_OFF, 1'b0, 2'h0}, '{8'h20, SPC_OFF, 1'b1, 2'h0},
    '{8'h01, SPC_RX_ONLY, 1'b0, 2'h1}, '{8'h40, SPC_TX_ONLY, 1'b0, 2'h2},
    '{8'h41, SPC_DUPLEX, 1'b0, 2'h3}, '{8'h61, SPC_DUPLEX, 1'b0, 2'h3}};
  spc_ctl i_dut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(4'hF), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_empty_flag(tx_empty_flag),
    .rx_full_flag(rx_full_flag), .err_events(err_events), .tx_shift_bit(tx_shift_bit),
    .serial_data_out(serial_data_out), .port_enabled(port_enabled), .port_mode(port_mode),
    .port_cfg(port_cfg), .dma_req(dma_req), .timer_run(timer_run), .irq(irq));
  spc_peer i_peer (.clock(clock), .rst(rst), .tx_cmd(tx_cmd), .rx_cmd(rx_cmd), .err_cmd(err_cmd),
    .tx_empty_flag(tx_empty_flag), .rx_full_flag(rx_full_flag), .err_events(err_events),
    .tx_shift_bit(tx_shift_bit));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [23:0] idx, input logic [31:0] wd);
    int n;
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      mismatches++;
      print_verdict();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic pulse_err(input spc_err_t e);
    err_cmd <= e;
    @(posedge clock);
    err_cmd <= '0;
    repeat (3) @(posedge clock);
  endtask
  task automatic flag_edge(input logic t, input logic r);
    tx_cmd <= 1'b0;
    rx_cmd <= 1'b0;
    repeat (2) @(posedge clock);
    tx_cmd <= t;
    rx_cmd <= r;
    repeat (3) @(posedge clock);
  endtask
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, tx_cmd, rx_cmd} = '0;
    avs_address = '0;
    avs_writedata = '0;
    err_cmd = '0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    bus(1'b0, `SPC_CTRL_IDX, 0);
    chk("ctrl reset", 32'h0, rd);
    chk("irq reset", 32'h0, irq);
    bus(1'b0, 24'h000010, 0);
    chk("unmapped", 32'h0, rd);
    tx_cmd <= 1'b1;
    rx_cmd <= 1'b1;
    // dma rows keep data interrupts off
    foreach (rows[i]) begin
      bus(1'b1, `SPC_CTRL_IDX, rows[i].ctl);
      bus(1'b0, `SPC_CTRL_IDX, 0);
      chk("ctrl back", rows[i].ctl, rd);
      chk("mode", rows[i].m, port_mode);
      chk("timer run", rows[i].tr, timer_run);
      chk("dma", rows[i].dma, dma_req);
    end
    bus(1'b1, `SPC_CTRL_IDX, 32'h01);
    repeat (3) @(posedge clock);
    chk("slave ones", 32'h1, serial_data_out);
    bus(1'b1, `SPC_CTRL_IDX, 32'h03);
    chk("master rx mode", SPC_RX_ONLY, port_mode);
    bus(1'b1, `SPC_CTRL_IDX, 32'h01);
    repeat (3) @(posedge clock);
    pulse_err(4'h2);
    chk("irq masked", 32'h0, irq);
    bus(1'b0, `SPC_STAT_IDX, 0);
    chk("abort status", 32'h10, rd);
    bus(1'b1, `SPC_MASK_IDX, 32'h7F);
    chk("irq abort", 32'h1, irq);
    bus(1'b1, `SPC_STAT_IDX, 32'h10);
    chk("irq cleared", 32'h0, irq);
    bus(1'b1, `SPC_CTRL_IDX, 32'h41);
    flag_edge(1'b1, 1'b1);
    chk("no data irq", 32'h0, irq);
    bus(1'b1, `SPC_CTRL_IDX, 32'hC1);
    flag_edge(1'b1, 1'b0);
    chk("tx data irq", 32'h1, irq);
    bus(1'b1, `SPC_STAT_IDX, 32'h7F);
    bus(1'b1, `SPC_CTRL_IDX, 32'h81);
    flag_edge(1'b1, 1'b1);
    bus(1'b0, `SPC_STAT_IDX, 0);
    chk("rx only status", 32'h2, rd);
    bus(1'b0, `SPC_FLAGS_IDX, 0);
    chk("tx flag shown", 32'h3, rd);
    print_verdict();
  end
endmodule // spc_ctl_bench
bind spc_ctl spc_ctl_asserts i_chk (.clock(clock), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .tx_empty_flag(tx_empty_flag),
  .rx_full_flag(rx_full_flag), .err_events(err_events), .tx_shift_bit(tx_shift_bit),
  .serial_data_out(serial_data_out), .port_enabled(port_enabled), .port_mode(port_mode),
  .port_cfg(port_cfg), .dma_req(dma_req), .timer_run(timer_run), .irq(irq));
